// File: hdl/lpc_chan_rate.sv
/*
 * One channel's poll timing: in sleep polling, emits a poll strike each base tick, or each
 * fourth base tick when slow. Assumes base_tick is a one-cycle pulse.
 */
`default_nettype none
module lpc_chan_rate
    import lpc_pkg::*;
(
    input wire logic sys_clk,
    input wire logic srst,
    input wire logic sleep_polling_state,
    input wire logic base_tick,
    input wire logic slow,
    output logic poll_strike,
    output lpc_rate_t rate
);
    logic [1:0] tick_count;
    wire logic last_of_four;

    assign last_of_four = (tick_count == 2'(LPC_SLOW_FACTOR - 1));

    always_ff @(posedge sys_clk) begin
        if (srst || !sleep_polling_state) begin
            tick_count <= 2'h0;
        end else if (base_tick) begin
            tick_count <= last_of_four ? 2'h0 : tick_count + 2'h1;
        end
    end

    // slow channel fires on every fourth tick only
    assign poll_strike = sleep_polling_state && base_tick &&
        (!slow || last_of_four);
    assign rate = !sleep_polling_state ? LPC_RATE_OFF :
        (slow ? LPC_RATE_SLOW : LPC_RATE_NORMAL);
endmodule : lpc_chan_rate
`default_nettype wire

// File: hdl/lpc_poll_config.sv
/*
 * Sleep-polling configuration bank: three registers reached by 32-bit
 * frames, steering per-channel poll current and poll rate.
 * Assumes frames arrive already deserialised, one-cycle frame_valid,
 * on sys_clk; base_tick comes from the sleep-polling rate timer.
 */
//
// Overview of operation
// - ground channel bit 0 sources normal 1.0 mA poll current.
// - ground channel bit 1 polls with the programmed wetting current level.
// - base poll rate comes from the sleep config, used when slow bit clear.
// - slow bit 0 polls at the normal selected rate, both channel groups.
// - slow bit 1 makes the polling interval four times longer.
// - current-select register at address 0x17, bit 24 selects read/write.
// - programmable slow register at 0x18, bits 7..0, rest read zero.
// - ground slow register at 0x19, low 14 bits, upper bits unused.
// - answer carries fault in bit 23, interrupt in 22, data in 21..0.
`default_nettype none
module lpc_poll_config
    import lpc_pkg::*;
(
    input wire logic sys_clk,
    input wire logic srst,
    input wire logic frame_valid,
    input wire logic [LPC_FRAME_W-1:0] frame_in,
    input wire logic fault_status,
    input wire logic int_flag,
    input wire logic sleep_polling_state,
    input wire logic base_tick,
    output logic [LPC_FRAME_W-1:0] frame_out,
    output logic answer_valid,
    output lpc_setting_t settings,
    output logic [LPC_NUM_GND-1:0] gnd_use_wetting_level,
    output logic [LPC_NUM_GND-1:0] gnd_normal_current,
    output logic [LPC_NUM_GND-1:0] gnd_poll_strike,
    output logic [LPC_NUM_PRG-1:0] prg_poll_strike
);
    logic [LPC_NUM_GND-1:0] gnd_cur;
    logic [LPC_NUM_GND-1:0] gnd_slow;
    logic [LPC_NUM_PRG-1:0] prg_slow;

    wire logic [6:0] addr;
    wire logic is_write;
    wire logic hit_cur;
    wire logic hit_pslow;
    wire logic hit_gslow;
    wire logic [LPC_DATA_W-1:0] wdata;
    wire logic [LPC_DATA_W-1:0] rdata;

    assign addr = frame_in[LPC_ADDR_MSB:LPC_ADDR_LSB];
    assign is_write = frame_in[LPC_RW_BIT];
    assign wdata = frame_in[LPC_DATA_W-1:0];
    assign hit_cur = frame_valid && (addr == LPC_ADDR_GND_CUR);
    assign hit_pslow = frame_valid && (addr == LPC_ADDR_PRG_SLOW);
    assign hit_gslow = frame_valid && (addr == LPC_ADDR_GND_SLOW);

    // unused bits stay zero on read
    assign rdata = hit_cur ? LPC_DATA_W'(gnd_cur) :
        hit_pslow ? LPC_DATA_W'(prg_slow) :
        hit_gslow ? LPC_DATA_W'(gnd_slow) :
        {LPC_DATA_W{1'b0}};

    // writes keep only the channel bits
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            gnd_cur <= LPC_GND_RESET;
        end else if (hit_cur && is_write) begin
            gnd_cur <= wdata[LPC_NUM_GND-1:0];
        end
    end

    always_ff @(posedge sys_clk) begin
        if (srst) begin
            prg_slow <= LPC_PRG_RESET;
        end else if (hit_pslow && is_write) begin
            prg_slow <= wdata[LPC_NUM_PRG-1:0];
        end
    end

    always_ff @(posedge sys_clk) begin
        if (srst) begin
            gnd_slow <= LPC_GND_RESET;
        end else if (hit_gslow && is_write) begin
            gnd_slow <= wdata[LPC_NUM_GND-1:0];
        end
    end

    // answer returns the register state seen before this frame's write
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            frame_out <= {LPC_FRAME_W{1'b0}};
            answer_valid <= 1'b0;
        end else begin
            answer_valid <= frame_valid;
            if (frame_valid) begin
                frame_out <= {frame_in[LPC_ADDR_MSB:LPC_RW_BIT],
                    fault_status, int_flag, rdata};
            end
        end
    end

    assign settings = '{gnd_use_wetting: gnd_cur, gnd_slow: gnd_slow,
        prg_slow: prg_slow};
    assign gnd_use_wetting_level = gnd_cur;
    assign gnd_normal_current = ~gnd_cur;

    genvar g;
    generate
        for (g = 0; g < LPC_NUM_GND + LPC_NUM_PRG; g++) begin : g_chan
            wire logic slow_bit;
            wire logic strike;
            if (g < LPC_NUM_GND) begin : g_gnd
                assign slow_bit = gnd_slow[g];
                assign gnd_poll_strike[g] = strike;
            end else begin : g_prg
                assign slow_bit = prg_slow[g-LPC_NUM_GND];
                assign prg_poll_strike[g-LPC_NUM_GND] = strike;
            end
            // base tick from the sleep config timer, per-bit slowdown
            lpc_chan_rate u_rate (
                .sys_clk(sys_clk),
                .srst(srst),
                .sleep_polling_state(sleep_polling_state),
                .base_tick(base_tick),
                .slow(slow_bit),
                .poll_strike(strike),
                .rate()
            );
        end
    endgenerate

    property p_write_cur;
        @(posedge sys_clk) disable iff (srst)
        (frame_valid && is_write && addr == LPC_ADDR_GND_CUR) |=>
            gnd_cur == $past(frame_in[LPC_NUM_GND-1:0]);
    endproperty
    a_write_cur: assert property (p_write_cur)
        else $error("current select write not stored");

    property p_write_pslow;
        @(posedge sys_clk) disable iff (srst)
        (frame_valid && is_write && addr == LPC_ADDR_PRG_SLOW) |=>
            prg_slow == $past(frame_in[LPC_NUM_PRG-1:0]);
    endproperty
    a_write_pslow: assert property (p_write_pslow)
        else $error("programmable slow write not stored");

    property p_write_gslow;
        @(posedge sys_clk) disable iff (srst)
        (frame_valid && is_write && addr == LPC_ADDR_GND_SLOW) |=>
            gnd_slow == $past(frame_in[LPC_NUM_GND-1:0]);
    endproperty
    a_write_gslow: assert property (p_write_gslow)
        else $error("ground slow write not stored");

    property p_answer_flags;
        @(posedge sys_clk) disable iff (srst)
        frame_valid |=> answer_valid &&
            frame_out[LPC_FAULT_BIT] == $past(fault_status) &&
            frame_out[LPC_INT_BIT] == $past(int_flag);
    endproperty
    a_answer_flags: assert property (p_answer_flags)
        else $error("answer flags wrong");

    property p_unused_zero;
        @(posedge sys_clk) disable iff (srst)
        answer_valid |-> frame_out[LPC_DATA_W-1:LPC_NUM_GND] == '0 &&
            (!$past(hit_pslow) ||
            frame_out[LPC_DATA_W-1:LPC_NUM_PRG] == '0);
    endproperty
    a_unused_zero: assert property (p_unused_zero)
        else $error("unused data bits not zero");

    property p_current_sel;
        @(posedge sys_clk) disable iff (srst)
        (gnd_use_wetting_level ^ gnd_normal_current) == '1 &&
            gnd_use_wetting_level == settings.gnd_use_wetting;
    endproperty
    a_current_sel: assert property (p_current_sel)
        else $error("poll current selection inconsistent");

    property p_fast_follows_tick;
        @(posedge sys_clk) disable iff (srst)
        (sleep_polling_state && base_tick && !gnd_slow[0]) |->
            gnd_poll_strike[0];
    endproperty
    a_fast_follows_tick: assert property (p_fast_follows_tick)
        else $error("normal channel missed a base tick");

    property p_slow_spacing;
        @(posedge sys_clk) disable iff (srst)
        (prg_slow[0] && prg_poll_strike[0] && base_tick)
            |=> (!prg_poll_strike[0] || !prg_slow[0]) [*3];
    endproperty
    a_slow_spacing: assert property (p_slow_spacing)
        else $error("slow channel polled too soon");

    property p_no_poll_awake;
        @(posedge sys_clk) disable iff (srst)
        !sleep_polling_state |-> gnd_poll_strike == '0 &&
            prg_poll_strike == '0;
    endproperty
    a_no_poll_awake: assert property (p_no_poll_awake)
        else $error("poll strike outside sleep polling");
endmodule : lpc_poll_config
`default_nettype wire

// File: pkg/lpc_pkg.sv
/*
 * Package for the sleep-polling configuration bank: frame layout, register
 * addresses, channel counts, reset values and the per-channel setting type.
 * Assumes a 32-bit frame, address in bits 31..25, read/write in bit 24.
 */
`default_nettype none
package lpc_pkg;
    localparam int LPC_FRAME_W = 32;
    localparam int LPC_ADDR_MSB = 31;
    localparam int LPC_ADDR_LSB = 25;
    localparam int LPC_RW_BIT = 24;
    localparam int LPC_FAULT_BIT = 23;
    localparam int LPC_INT_BIT = 22;
    localparam int LPC_DATA_W = 22;
    localparam int LPC_NUM_GND = 14;
    localparam int LPC_NUM_PRG = 8;
    localparam logic [6:0] LPC_ADDR_GND_CUR = 7'h17;
    localparam logic [6:0] LPC_ADDR_PRG_SLOW = 7'h18;
    localparam logic [6:0] LPC_ADDR_GND_SLOW = 7'h19;
    localparam logic [13:0] LPC_GND_RESET = 14'h0000;
    localparam logic [7:0] LPC_PRG_RESET = 8'h00;
    // slow polling stretches the interval by this factor
    localparam int LPC_SLOW_FACTOR = 4;
    localparam int LPC_NORMAL_CUR_UA = 1000;

    typedef struct packed {
        logic [LPC_NUM_GND-1:0] gnd_use_wetting;
        logic [LPC_NUM_GND-1:0] gnd_slow;
        logic [LPC_NUM_PRG-1:0] prg_slow;
    } lpc_setting_t;

    typedef enum logic [1:0] {
        LPC_RATE_OFF,
        LPC_RATE_NORMAL,
        LPC_RATE_SLOW
    } lpc_rate_t;
endpackage : lpc_pkg
`default_nettype wire

// File: verif/lpc_host_model.sv
/*
 * Host-side frame master for the sleep-polling configuration bank.
 * Assumes the bank answers one cycle after it takes a frame.
 */
`default_nettype none
module lpc_host_model
    import lpc_pkg::*;
(
    input wire logic sys_clk,
    input wire logic answer_valid,
    input wire logic [LPC_FRAME_W-1:0] frame_out,
    output logic frame_valid,
    output logic [LPC_FRAME_W-1:0] frame_in
);
    timeunit 1ns;
    timeprecision 100ps;
    initial begin
        frame_valid = 1'b0;
        frame_in = '0;
    end
    task automatic xfer(input logic [6:0] addr, input logic wr,
        input logic [21:0] data, output logic [LPC_FRAME_W-1:0] ans,
        output logic seen_valid);
        logic [LPC_FRAME_W-1:0] word;
        word = {addr, wr, 2'b00, data};
        @(posedge sys_clk);
        frame_valid <= 1'b1;
        frame_in <= word;
        @(posedge sys_clk);
        frame_valid <= 1'b0;
        // released lines show the inverse so stale data never matches
        frame_in <= ~word;
        #1;
        ans = frame_out;
        seen_valid = answer_valid;
    endtask : xfer
endmodule : lpc_host_model
`default_nettype wire

// File: verif/lpc_poll_config_test.sv
/*
 * Self-checking bench for the sleep-polling configuration bank.
 * Assumes the host model drives frames; bench drives the other inputs.
 */
`default_nettype none
module lpc_poll_config_test
    import lpc_pkg::*;
;
    timeunit 1ns;
    timeprecision 100ps;
    typedef struct {
        logic [6:0] addr;
        logic wr;
        logic [21:0] data;
        logic [21:0] exp;
    } lpc_row_t;
    logic sys_clk = 1'b0;
    logic srst = 1'b1;
    logic fault_status = 1'b0;
    logic int_flag = 1'b0;
    logic sleep_polling_state = 1'b0;
    logic base_tick = 1'b0;
    logic frame_valid, answer_valid, seen_valid;
    logic [LPC_FRAME_W-1:0] frame_in, frame_out, ans;
    lpc_setting_t settings;
    logic [LPC_NUM_GND-1:0] gnd_use_wetting_level, gnd_normal_current;
    logic [LPC_NUM_GND-1:0] gnd_poll_strike;
    logic [LPC_NUM_PRG-1:0] prg_poll_strike;
    int num_errors = 0;
    int comparisons = 0;
    int cycles = 0;
    lpc_row_t rows [15] = '{
        '{7'h17, 1'b0, 22'h0, 22'h0}, '{7'h18, 1'b0, 22'h0, 22'h0},
        '{7'h19, 1'b0, 22'h0, 22'h0}, '{7'h17, 1'b1, 22'h3FFFFF, 22'h0},
        '{7'h17, 1'b0, 22'h0, 22'h3FFF},
        '{7'h17, 1'b1, 22'h1234, 22'h3FFF},
        '{7'h17, 1'b0, 22'h3FFFFF, 22'h1234},
        '{7'h17, 1'b0, 22'h0, 22'h1234}, '{7'h18, 1'b1, 22'h3FFFFF, 22'h0},
        '{7'h18, 1'b0, 22'h0, 22'hFF}, '{7'h19, 1'b1, 22'h2AAAAA, 22'h0},
        '{7'h19, 1'b0, 22'h0, 22'h2AAA}, '{7'h16, 1'b1, 22'h3FFFFF, 22'h0},
        '{7'h1A, 1'b0, 22'h0, 22'h0}, '{7'h17, 1'b0, 22'h0, 22'h1234}};
    always #2 sys_clk = ~sys_clk;
    lpc_poll_config u_dut (
        .sys_clk(sys_clk), .srst(srst), .frame_valid(frame_valid),
        .frame_in(frame_in), .fault_status(fault_status),
        .int_flag(int_flag), .sleep_polling_state(sleep_polling_state),
        .base_tick(base_tick), .frame_out(frame_out),
        .answer_valid(answer_valid), .settings(settings),
        .gnd_use_wetting_level(gnd_use_wetting_level),
        .gnd_normal_current(gnd_normal_current),
        .gnd_poll_strike(gnd_poll_strike),
        .prg_poll_strike(prg_poll_strike));
    lpc_host_model u_host (
        .sys_clk(sys_clk), .answer_valid(answer_valid),
        .frame_out(frame_out), .frame_valid(frame_valid),
        .frame_in(frame_in));
    task automatic check(input string name, input logic [35:0] seen,
        input logic [35:0] exp);
        comparisons++;
        if (seen !== exp) begin
            num_errors++;
            $display("mismatch %s expected %h seen %h", name, exp, seen);
        end
    endtask : check
    task automatic finish_test();
        $display("comparisons %0d num_errors %0d", comparisons, num_errors);
        if (num_errors == 0 && comparisons > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : finish_test
    always @(posedge sys_clk) begin
        cycles <= cycles + 1;
        if (cycles == 3000) begin
            num_errors++;
            finish_test();
        end
    end
    initial begin
        repeat (6) @(posedge sys_clk);
        srst <= 1'b0;
        foreach (rows[i]) begin
            @(posedge sys_clk);
            fault_status <= i[0];
            int_flag <= i[1];
            u_host.xfer(rows[i].addr, rows[i].wr, rows[i].data, ans,
                seen_valid);
            check("answer_valid", seen_valid, 1'b1);
            check("frame_out", ans, {rows[i].addr, rows[i].wr, i[0], i[1],
                rows[i].exp});
        end
        check("settings", settings, {14'h1234, 14'h2AAA, 8'hFF});
        check("wetting", gnd_use_wetting_level, 14'h1234);
        check("normal", gnd_normal_current, 14'h2DCB);
        @(posedge sys_clk);
        base_tick <= 1'b1;
        #1;
        check("strike_awake", gnd_poll_strike, 14'h0000);
        @(posedge sys_clk);
        base_tick <= 1'b0;
        sleep_polling_state <= 1'b1;
        @(posedge sys_clk);
        for (int k = 0; k < 8; k++) begin
            @(posedge sys_clk);
            base_tick <= 1'b1;
            #1;
            check("gnd_strike", gnd_poll_strike,
                (k % 4 == 3) ? 14'h3FFF : 14'h1555);
            check("prg_strike", prg_poll_strike,
                (k % 4 == 3) ? 8'hFF : 8'h00);
            @(posedge sys_clk);
            base_tick <= 1'b0;
        end
        srst <= 1'b1;
        fault_status <= 1'b1;
        int_flag <= 1'b0;
        repeat (2) @(posedge sys_clk);
        srst <= 1'b0;
        #1;
        check("reset_settings", settings, 36'h0);
        check("reset_normal", gnd_normal_current, 14'h3FFF);
        check("reset_frame", frame_out, 32'h0);
        check("reset_valid", answer_valid, 1'b0);
        check("reset_strike", {gnd_poll_strike, prg_poll_strike},
            22'h0);
        // bank must take a frame right after a mid-run reset
        u_host.xfer(7'h19, 1'b0, 22'h0, ans, seen_valid);
        check("post_reset_valid", seen_valid, 1'b1);
        check("post_reset_frame", ans,
            {7'h19, 1'b0, 1'b1, 1'b0, 22'h0});
        finish_test();
    end
endmodule : lpc_poll_config_test
`default_nettype wire
